// *** inc/asf_pkg.sv ***
// Shared constants for the audio serial receive status block.
// Assumes a 32-bit APB slave with a 12-bit byte address.
package asf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_RXDATA = 12'h014;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int          CTRL_TRIG_LSB = 0;
  localparam int          CTRL_TRIG_W   = 3;
  localparam int          CTRL_THR_IE   = 3;
  localparam int          CTRL_ERR_IE   = 4;
  localparam int          CTRL_W        = 5;
  localparam logic [4:0]  CTRL_RST      = 5'h00;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int BIT_RX_FULL = 11;
  localparam int BIT_RX_THR  = 10;
  localparam int BIT_RX_OVF  = 9;
  localparam int BIT_RX_UDF  = 8;
  localparam int BIT_RIGHT   = 3;
  localparam int BIT_TX_IRQ  = 2;
  localparam int BIT_RX_IRQ  = 1;
  localparam int BIT_ANY_IRQ = 0;
  localparam int LVL_LSB     = 24;
  localparam int LVL_W       = 4;

  // ----------------------------------------------------------------
  // Buffer shape
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W     = 32;

endpackage

// *** design/asf_sync.sv ***
// Two-flop level synchroniser.
// Assumes the input is a level from another clock domain.
`timescale 1ns/1ps
module asf_sync
(
  // Destination clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic din,
  output logic      dout
);

  logic stage1;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // asf_sync

// *** design/asf_link_rx.sv ***
// Serial receive side on the link bit clock: assembles one word per
// word-select phase and announces it with a toggle.
// Assumes standard serial audio timing, data one bit clock after the
// word-select edge, most significant bit first.
`timescale 1ns/1ps
module asf_link_rx
#(
  parameter int WIDTH = asf_pkg::WORD_W
)
(
  // Link clock and reset
  input  wire logic             link_bclk,
  input  wire logic             rst_n,
  // Serial pins
  input  wire logic             link_ws,
  input  wire logic             link_sd,
  // Word out, held until the next toggle
  output logic [WIDTH-1:0]      word,
  output logic                  word_tgl
);

  logic [WIDTH-1:0] shreg;
  logic             ws_d;

  // The bit taken at a select edge is the last bit of the old word
  always_ff @(posedge link_bclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg    <= '0;
      ws_d     <= 1'b0;
      word     <= '0;
      word_tgl <= 1'b0;
    end
    else
    begin
      ws_d  <= link_ws;
      shreg <= {shreg[WIDTH-2:0], link_sd};
      if (ws_d != link_ws)
      begin
        word     <= {shreg[WIDTH-2:0], link_sd};
        word_tgl <= ~word_tgl;
      end
    end
  end

endmodule // asf_link_rx

// *** design/asf_rx_status.sv ***
// Receive buffer, receive status flags and interrupt summary, with an
// APB register slave.
// Assumes a link bit clock from the codec, and transmit logic that
// supplies its channel (link clock) and pending interrupt (pclk).
`timescale 1ns/1ps

// Notes on behaviour
// - The full bit reads 1 exactly when the buffer holds 8 words.
// - The level flag is set while the word count is at or above the trigger.
// - Once set, the level flag only drops after a data read takes the count below the trigger.
// - A word arriving into a full buffer sets the overrun flag, cleared by writing 1.
// - On overrun the oldest stored entry is replaced by the arriving word.
// - Reading the data port while empty sets the underrun flag, cleared by writing 1.
// - Bit 3 shows the channel of the word being transmitted, 1 for right.
// - Bit 2 shows a pending transmit interrupt.
// - Bit 1 shows a pending receive interrupt.
// - Bit 0 is the OR of the transmit and receive interrupt bits.
// - The buffer holds 8 words of 32 bits, drained by reads, level in a 4-bit field.
module asf_rx_status
#(
  parameter int DEPTH = asf_pkg::FIFO_DEPTH,
  parameter int WIDTH = asf_pkg::WORD_W
)
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  // APB answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link
  input  wire logic        link_bclk,
  input  wire logic        link_ws,
  input  wire logic        link_sd,
  // Transmit side indications
  input  wire logic        tx_right_chan,
  input  wire logic        tx_irq_req
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [3:0] DEPTH_C = 4'(DEPTH);

  if (DEPTH < 2 || DEPTH > 8 || (1 << PW) != DEPTH || WIDTH != 32)
  begin : g_bad_cfg
    $error("asf_rx_status: unsupported DEPTH or WIDTH");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  // ----------------------------------------------------------------
  // Link domain and crossing
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] link_word;
  logic             link_tgl;
  logic             tgl_s;
  logic             tgl_seen;
  logic             right_s;
  logic             push;

  asf_link_rx #(.WIDTH(WIDTH)) u_link
  (
    .link_bclk (link_bclk),
    .rst_n     (presetn),
    .link_ws   (link_ws),
    .link_sd   (link_sd),
    .word      (link_word),
    .word_tgl  (link_tgl)
  );

  asf_sync u_tgl_sync
  (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (link_tgl),
    .dout  (tgl_s)
  );

  asf_sync u_right_sync
  (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (tx_right_chan),
    .dout  (right_s)
  );

  // Word stays stable for a whole link word, far longer than the sync
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tgl_seen <= 1'b0;
    else
      tgl_seen <= tgl_s;
  end

  assign push = tgl_s ^ tgl_seen;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic access;
  logic rd_data;
  logic wr_ctrl;
  logic wr_stat;
  logic mapped;

  assign access  = psel & penable & pready;
  assign mapped  = hit(paddr, asf_pkg::OFS_CTRL)
                 | hit(paddr, asf_pkg::OFS_STATUS)
                 | hit(paddr, asf_pkg::OFS_RXDATA);
  assign rd_data = access & ~pwrite & hit(paddr, asf_pkg::OFS_RXDATA);
  assign wr_ctrl = access & pwrite & hit(paddr, asf_pkg::OFS_CTRL);
  assign wr_stat = access & pwrite & hit(paddr, asf_pkg::OFS_STATUS);

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [3:0]       rx_word_count;
  logic [3:0]       next_count;
  logic             pop;
  logic             overrun_ev;
  logic             underrun_ev;

  assign pop         = rd_data & (rx_word_count != 4'h0);
  assign underrun_ev = rd_data & (rx_word_count == 4'h0);
  assign overrun_ev  = push & ~pop & (rx_word_count == DEPTH_C);

  always_comb
  begin
    next_count = rx_word_count;
    if (push & ~pop & ~overrun_ev)
      next_count = rx_word_count + 4'h1;
    else if (pop & ~push)
      next_count = rx_word_count - 4'h1;
  end

  always_ff @(posedge pclk)
  begin
    if (overrun_ev)
      mem[rd_ptr] <= link_word;
    else if (push)
      mem[wr_ptr] <= link_word;
  end

  // Overrun replaces the oldest entry; pointers stay so the new word is read first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      rx_word_count <= 4'h0;
    end
    else
    begin
      if (push & ~overrun_ev)
        wr_ptr <= wr_ptr + PW'(1);
      if (pop)
        rd_ptr <= rd_ptr + PW'(1);
      rx_word_count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [asf_pkg::CTRL_W-1:0]      ctrl;
  logic [asf_pkg::CTRL_TRIG_W-1:0] rx_level_trigger;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= asf_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl <= pwdata[asf_pkg::CTRL_W-1:0];
  end

  assign rx_level_trigger =
    ctrl[asf_pkg::CTRL_TRIG_LSB +: asf_pkg::CTRL_TRIG_W];

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic rx_buffer_full;
  logic rx_level_reached_flag;
  logic rx_overrun_flag;
  logic rx_underrun_flag;
  logic right_chan;
  logic tx_irq_flag;
  logic rx_irq_flag;
  logic any_irq_flag;
  logic next_thr;
  logic next_ovf;
  logic next_udf;
  logic next_rx_irq;
  logic next_tx_irq;

  always_comb
  begin
    next_thr = rx_level_reached_flag;
    if (next_count >= {1'b0, rx_level_trigger})
      next_thr = 1'b1;
    else if (pop)
      next_thr = 1'b0;
  end

  // Set beats a simultaneous write-one clear
  always_comb
  begin
    next_ovf = rx_overrun_flag;
    next_udf = rx_underrun_flag;
    if (wr_stat & pwdata[asf_pkg::BIT_RX_OVF])
      next_ovf = 1'b0;
    if (wr_stat & pwdata[asf_pkg::BIT_RX_UDF])
      next_udf = 1'b0;
    if (overrun_ev)
      next_ovf = 1'b1;
    if (underrun_ev)
      next_udf = 1'b1;
  end

  assign next_tx_irq = tx_irq_req;
  assign next_rx_irq = (ctrl[asf_pkg::CTRL_THR_IE] & next_thr)
                     | (ctrl[asf_pkg::CTRL_ERR_IE] & (next_ovf | next_udf));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_buffer_full        <= 1'b0;
      rx_level_reached_flag <= 1'b0;
      rx_overrun_flag       <= 1'b0;
      rx_underrun_flag      <= 1'b0;
      right_chan            <= 1'b0;
      tx_irq_flag           <= 1'b0;
      rx_irq_flag           <= 1'b0;
      any_irq_flag          <= 1'b0;
    end
    else
    begin
      rx_buffer_full        <= (next_count == DEPTH_C);
      rx_level_reached_flag <= next_thr;
      rx_overrun_flag       <= next_ovf;
      rx_underrun_flag      <= next_udf;
      right_chan            <= right_s;
      tx_irq_flag           <= next_tx_irq;
      rx_irq_flag           <= next_rx_irq;
      any_irq_flag          <= next_tx_irq | next_rx_irq;
    end
  end

  // ----------------------------------------------------------------
  // Read mux and answer
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[asf_pkg::LVL_LSB +: asf_pkg::LVL_W] = rx_word_count;
    status_word[asf_pkg::BIT_RX_FULL] = rx_buffer_full;
    status_word[asf_pkg::BIT_RX_THR]  = rx_level_reached_flag;
    status_word[asf_pkg::BIT_RX_OVF]  = rx_overrun_flag;
    status_word[asf_pkg::BIT_RX_UDF]  = rx_underrun_flag;
    status_word[asf_pkg::BIT_RIGHT]   = right_chan;
    status_word[asf_pkg::BIT_TX_IRQ]  = tx_irq_flag;
    status_word[asf_pkg::BIT_RX_IRQ]  = rx_irq_flag;
    status_word[asf_pkg::BIT_ANY_IRQ] = any_irq_flag;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit(paddr, asf_pkg::OFS_CTRL))
      next_rdata[asf_pkg::CTRL_W-1:0] = ctrl;
    else if (hit(paddr, asf_pkg::OFS_STATUS))
      next_rdata = status_word;
    else if (hit(paddr, asf_pkg::OFS_RXDATA) &&
             rx_word_count != 4'h0)
      next_rdata = mem[rd_ptr];
  end

  // One wait state: answer on the second access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (psel & penable & ~pready)
    begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  full_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_buffer_full == (rx_word_count == DEPTH_C))
    else $error("full bit disagrees with word count");

  thr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_word_count >= {1'b0, rx_level_trigger}) && !pop
      |=> rx_level_reached_flag)
    else $error("level flag low at or above trigger");

  thr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(rx_level_reached_flag) |-> $past(pop))
    else $error("level flag dropped without a data read");

  ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_ev |=> rx_overrun_flag ##1 1'b1)
    else $error("overrun flag not set");

  ovf_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_ev |=> (rx_word_count == DEPTH_C) && $stable(wr_ptr))
    else $error("overrun changed count or write slot");

  udf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (underrun_ev && !push) |=> rx_underrun_flag && (rx_word_count == 4'h0))
    else $error("underrun flag not set");

  w1c_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_overrun_flag && wr_stat && !pwdata[asf_pkg::BIT_RX_OVF])
      |=> rx_overrun_flag)
    else $error("writing zero cleared the overrun flag");

  irq_any_a: assert property (@(posedge pclk) disable iff (!presetn)
    any_irq_flag == (tx_irq_flag | rx_irq_flag))
    else $error("summary interrupt is not the OR");

  tx_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_irq_req |=> tx_irq_flag && any_irq_flag)
    else $error("transmit interrupt not shown");

  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && hit(paddr, asf_pkg::OFS_STATUS))
      |-> prdata[7:4] == 4'h0)
    else $error("reserved status bits not zero");

endmodule // asf_rx_status

// *** tb/asf_codec_model.sv ***
// Codec model: drives serial words into the receive block.
// Assumes the bench calls its tasks; bit clock runs only while a task runs.
`timescale 1ns/1ps
module asf_codec_model
(
  // Serial link
  output logic link_bclk,
  output logic link_ws,
  output logic link_sd
);
  initial
  begin
    link_bclk = 1'b0;
    link_ws   = 1'b0;
    link_sd   = 1'b0;
  end

  // One 48 ns bit clock period
  task automatic tick();
    #24 link_bclk = 1'b1;
    #24 link_bclk = 1'b0;
  endtask

  // MSB first; the LSB rides with the select flip that stores it
  task automatic send(input logic [31:0] w);
    for (int i = 31; i > 0; i--)
    begin
      link_sd = w[i];
      tick();
    end
    link_sd = w[0];
    link_ws = ~link_ws;
    tick();
    // Idle data line must not keep showing the last bit
    link_sd = ~link_sd;
  endtask
endmodule // asf_codec_model

// *** tb/i2s_rx_fifo_status_flags_bench.sv ***
// Self-checking bench for the receive status block.
// Assumes the design header in inc/ and the codec model in tb/.
`timescale 1ns/1ps
module i2s_rx_fifo_status_flags_bench;
  typedef struct packed
  {
    logic [31:0] e;
    logic [31:0] m;
    logic        err;
  } asf_note_t;

  logic        pclk          = 1'b0;
  logic        presetn       = 1'b0;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [11:0] paddr         = 12'h000;
  logic [31:0] pwdata        = 32'h0;
  logic        tx_right_chan = 1'b0;
  logic        tx_irq_req    = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        link_bclk;
  logic        link_ws;
  logic        link_sd;
  asf_note_t   q[$];
  asf_note_t   nt;
  logic [31:0] words[$];
  logic [31:0] rd;
  int          n_errors      = 0;
  int          checks_done   = 0;
  int          trig          = 0;
  logic        ie            = 1'b0;

  always #10 pclk = ~pclk;

  asf_rx_status u_dut
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .link_bclk     (link_bclk),
    .link_ws       (link_ws),
    .link_sd       (link_sd),
    .tx_right_chan (tx_right_chan),
    .tx_irq_req    (tx_irq_req)
  );

  asf_codec_model u_codec
  (
    .link_bclk (link_bclk),
    .link_ws   (link_ws),
    .link_sd   (link_sd)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------
  // APB master: note the expectation, then hold until pready
  // --------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [31:0] e,
                      input logic [31:0] m, input logic err);
    q.push_back(asf_note_t'{e, m, err});
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdx(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    xfer(1'b0, a, 32'h0, e, m, 1'b0);
  endtask

  task automatic wrx(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  // Words arrive over the link; allow the crossing to settle
  task automatic push(input int n);
    logic [31:0] w;
    repeat (n)
    begin
      w = $urandom;
      words.push_back(w);
      u_codec.send(w);
    end
    repeat (8) @(posedge pclk);
  endtask

  // Expected status word from count, sticky flags and transmit inputs
  function automatic logic [31:0] st(input int c, input logic ov,
                                     input logic ud, input logic r,
                                     input logic t);
    logic th;
    logic rx;
    th = (c >= trig);
    rx = (ie & th) | (ie & (ov | ud));
    return {4'h0, c[3:0], 12'h000, c == 8, th, ov, ud, 4'h0,
            r, t, rx, t | rx};
  endfunction

  // Monitor: every answer takes the oldest note
  always @(posedge pclk)
    if (pready === 1'b1)
    begin
      if (q.size() > 0)
        nt = q.pop_front();
      else
        nt = asf_note_t'{32'hffffffff, 32'hffffffff, 1'b1};
      check(prdata & nt.m, nt.e & nt.m);
      check({31'h0, pslverr}, {31'h0, nt.err});
    end

  initial
  begin
    #400000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h1a0ec4b4));
    fork
      repeat (4) u_codec.tick();
      repeat (20) @(posedge pclk);
    join
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdx(asf_pkg::OFS_CTRL, 32'h0, 32'h1f);
    rdx(asf_pkg::OFS_STATUS, st(0, 0, 0, 0, 0), '1);
    xfer(1'b0, 12'h00c, 32'h0, 32'h0, '1, 1'b1);
    // Raising the trigger leaves the level flag set until a data read
    wrx(asf_pkg::OFS_CTRL, 32'h0000001b);
    trig = 3;
    ie   = 1'b1;
    // Prime the link once, then drain whatever it stored
    u_codec.send(32'h0);
    repeat (8) @(posedge pclk);
    rdx(asf_pkg::OFS_STATUS, 32'h00000400, 32'h00000400);
    repeat (rd[27:24]) rdx(asf_pkg::OFS_RXDATA, 32'h0, 32'h0);
    push(2);
    rdx(asf_pkg::OFS_STATUS, st(2, 0, 0, 0, 0), '1);
    push(1);
    rdx(asf_pkg::OFS_STATUS, st(3, 0, 0, 0, 0), '1);
    push(5);
    rdx(asf_pkg::OFS_STATUS, st(8, 0, 0, 0, 0), '1);
    push(1);
    rdx(asf_pkg::OFS_STATUS, st(8, 1, 0, 0, 0), '1);
    wrx(asf_pkg::OFS_STATUS, 32'h000000f0);
    // Oldest entry is replaced by the overrunning word
    words[0] = words[8];
    void'(words.pop_back());
    for (int i = 7; i >= 0; i--)
    begin
      rdx(asf_pkg::OFS_RXDATA, words.pop_front(), '1);
      rdx(asf_pkg::OFS_STATUS, st(i, 1, 0, 0, 0), '1);
    end
    rdx(asf_pkg::OFS_RXDATA, 32'h0, '1);
    rdx(asf_pkg::OFS_STATUS, st(0, 1, 1, 0, 0), '1);
    wrx(asf_pkg::OFS_STATUS, 32'h00000300);
    rdx(asf_pkg::OFS_STATUS, st(0, 0, 0, 0, 0), '1);
    repeat (6)
    begin
      tx_right_chan <= 1'($urandom);
      tx_irq_req    <= 1'($urandom);
      // Bit clock runs here in case the channel is taken on it
      fork
        repeat (6) @(posedge pclk);
        repeat (2) u_codec.tick();
      join
      rdx(asf_pkg::OFS_STATUS,
          st(0, 0, 0, tx_right_chan, tx_irq_req), '1);
    end
    check(32'(q.size()), 32'h0);
    complete_run();
  end
endmodule // i2s_rx_fifo_status_flags_bench
